// [shared/rsrb_map.svh]
`ifndef RSRB_MAP_SVH
`define RSRB_MAP_SVH

// register offsets within the status space
`define RSRB_ADDR_WOR_LOW 6'h37
`define RSRB_ADDR_PKT_STATUS 6'h38
`define RSRB_ADDR_CAL_READ 6'h39
`define RSRB_ADDR_TX_LEVEL 6'h3A
`define RSRB_ADDR_RX_LEVEL 6'h3B

// access header byte layout
`define RSRB_HDR_READ_BIT 7
`define RSRB_HDR_BURST_BIT 6
`define RSRB_HDR_ADDR_MSB 5
`define RSRB_HDR_ADDR_LSB 0

// packet status field positions
`define RSRB_PKT_CRC_MATCH 7
`define RSRB_PKT_CARRIER 6
`define RSRB_PKT_PREAMBLE 5
`define RSRB_PKT_CHANNEL_CLEAR 4
`define RSRB_PKT_SYNC 3
`define RSRB_PKT_OUT_TWO 2
`define RSRB_PKT_OUT_ONE 1
`define RSRB_PKT_OUT_ZERO 0

// buffer level field positions
`define RSRB_LVL_FLAG_BIT 7
`define RSRB_LVL_COUNT_MSB 6
`define RSRB_LVL_COUNT_LSB 0

// reset and set values
`define RSRB_BYTE_RESET 8'h00
`define RSRB_COUNT_RESET 7'h00
`define RSRB_BIT_RESET 1'b0
`define RSRB_BIT_SET 1'b1

`endif

// [shared/rsrb_pkg.sv]
package rsrb_pkg;
    typedef logic [7:0] rsrb_byte_t;
    typedef logic [6:0] rsrb_count_t;
    typedef logic [5:0] rsrb_addr_t;
    typedef enum logic [2:0] {
        RSRB_SEL_NONE,
        RSRB_SEL_WOR_LOW,
        RSRB_SEL_PKT,
        RSRB_SEL_CAL,
        RSRB_SEL_TX,
        RSRB_SEL_RX
    } rsrb_sel_e;
endpackage

// [shared/rsrb_flag_if.sv]
interface rsrb_flag_if;
    logic crc_done;
    logic crc_match;
    logic rx_enter;
    logic tx_underflow_evt;
    logic tx_flush;
    logic rx_overflow_evt;
    logic rx_flush;
    logic crc_match_flag;
    logic tx_underflow_flag;
    logic rx_overflow_flag;

    modport source (
        output crc_done,
        output crc_match,
        output rx_enter,
        output tx_underflow_evt,
        output tx_flush,
        output rx_overflow_evt,
        output rx_flush,
        input crc_match_flag,
        input tx_underflow_flag,
        input rx_overflow_flag
    );

    modport keeper (
        input crc_done,
        input crc_match,
        input rx_enter,
        input tx_underflow_evt,
        input tx_flush,
        input rx_overflow_evt,
        input rx_flush,
        output crc_match_flag,
        output tx_underflow_flag,
        output rx_overflow_flag
    );
endinterface

// [verilog/rsrb_flag_keeper.sv]
`include "rsrb_map.svh"

module rsrb_flag_keeper (
    input wire logic clk_i,
    input wire logic reset_i,
    rsrb_flag_if.keeper flg
);
    logic crc_match_ff;
    logic tx_underflow_ff;
    logic rx_overflow_ff;

    // a fresh comparison result outranks the rx-entry clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            crc_match_ff <= `RSRB_BIT_RESET;
        end else if (flg.crc_done) begin
            crc_match_ff <= flg.crc_match;
        end else if (flg.rx_enter) begin
            crc_match_ff <= `RSRB_BIT_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_underflow_ff <= `RSRB_BIT_RESET;
        end else if (flg.tx_underflow_evt) begin
            tx_underflow_ff <= `RSRB_BIT_SET;
        end else if (flg.tx_flush) begin
            tx_underflow_ff <= `RSRB_BIT_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_overflow_ff <= `RSRB_BIT_RESET;
        end else if (flg.rx_overflow_evt) begin
            rx_overflow_ff <= `RSRB_BIT_SET;
        end else if (flg.rx_flush) begin
            rx_overflow_ff <= `RSRB_BIT_RESET;
        end
    end

    assign flg.crc_match_flag = crc_match_ff;
    assign flg.tx_underflow_flag = tx_underflow_ff;
    assign flg.rx_overflow_flag = rx_overflow_ff;
endmodule

// [verilog/rsrb_status_bank.sv]
`include "rsrb_map.svh"

module rsrb_status_bank (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic rd_req_i,
    input wire logic [7:0] rd_header_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic rd_miss_o,
    input wire logic [15:0] wake_timer_count_i,
    input wire logic crc_done_i,
    input wire logic crc_match_i,
    input wire logic rx_enter_i,
    input wire logic carrier_sense_i,
    input wire logic preamble_quality_met_i,
    input wire logic channel_clear_flag_i,
    input wire logic sync_found_flag_i,
    input wire logic gp_output_two_i,
    input wire logic gp_output_one_i,
    input wire logic gp_output_zero_i,
    input wire logic output_two_invert_i,
    input wire logic output_zero_invert_i,
    input wire logic [7:0] osc_tuning_i,
    input wire logic [6:0] transmit_byte_count_i,
    input wire logic tx_underflow_evt_i,
    input wire logic tx_flush_i,
    input wire logic [6:0] receive_byte_count_i,
    input wire logic rx_overflow_evt_i,
    input wire logic rx_flush_i
);
    rsrb_flag_if flg ();

    assign flg.crc_done = crc_done_i;
    assign flg.crc_match = crc_match_i;
    assign flg.rx_enter = rx_enter_i;
    assign flg.tx_underflow_evt = tx_underflow_evt_i;
    assign flg.tx_flush = tx_flush_i;
    assign flg.rx_overflow_evt = rx_overflow_evt_i;
    assign flg.rx_flush = rx_flush_i;

    rsrb_flag_keeper u_flags (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .flg(flg)
    );

    // status is sampled into flops each cycle so a read answer is a
    // glitch-free image one cycle old rather than a live mux of pins
    rsrb_pkg::rsrb_byte_t wake_timer_low_byte_ff;
    rsrb_pkg::rsrb_byte_t packet_and_output_status_ff;
    rsrb_pkg::rsrb_byte_t oscillator_calibration_readback_ff;
    rsrb_pkg::rsrb_byte_t transmit_buffer_level_ff;
    rsrb_pkg::rsrb_byte_t receive_buffer_level_ff;
    rsrb_pkg::rsrb_byte_t nxt_packet_and_output_status;
    rsrb_pkg::rsrb_byte_t rd_data_ff;
    rsrb_pkg::rsrb_byte_t nxt_rd_data;
    rsrb_pkg::rsrb_sel_e rd_sel;
    logic rd_valid_ff;
    logic rd_miss_ff;
    logic gp_two_plain;
    logic gp_zero_plain;

    function automatic rsrb_pkg::rsrb_sel_e decode_header(
        input logic [7:0] hdr
    );
        rsrb_pkg::rsrb_addr_t addr;
        rsrb_pkg::rsrb_sel_e sel;
        addr = hdr[`RSRB_HDR_ADDR_MSB:`RSRB_HDR_ADDR_LSB];
        sel = rsrb_pkg::RSRB_SEL_NONE;
        // status space needs both read and burst bits; otherwise the same
        // offsets belong to strobes and are refused here with a miss
        if (hdr[`RSRB_HDR_READ_BIT] && hdr[`RSRB_HDR_BURST_BIT]) begin
            unique case (addr)
                `RSRB_ADDR_WOR_LOW: sel = rsrb_pkg::RSRB_SEL_WOR_LOW;
                `RSRB_ADDR_PKT_STATUS: sel = rsrb_pkg::RSRB_SEL_PKT;
                `RSRB_ADDR_CAL_READ: sel = rsrb_pkg::RSRB_SEL_CAL;
                `RSRB_ADDR_TX_LEVEL: sel = rsrb_pkg::RSRB_SEL_TX;
                `RSRB_ADDR_RX_LEVEL: sel = rsrb_pkg::RSRB_SEL_RX;
                default: sel = rsrb_pkg::RSRB_SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    function automatic rsrb_pkg::rsrb_byte_t pack_level(
        input logic flag,
        input logic [6:0] count
    );
        rsrb_pkg::rsrb_byte_t b;
        b = `RSRB_BYTE_RESET;
        b[`RSRB_LVL_FLAG_BIT] = flag;
        b[`RSRB_LVL_COUNT_MSB:`RSRB_LVL_COUNT_LSB] = count;
        return b;
    endfunction

    // outputs two and zero arrive pin-side, after their invert option
    assign gp_two_plain = gp_output_two_i ^ output_two_invert_i;
    assign gp_zero_plain = gp_output_zero_i ^ output_zero_invert_i;

    always_comb begin
        nxt_packet_and_output_status = `RSRB_BYTE_RESET;
        nxt_packet_and_output_status[`RSRB_PKT_CRC_MATCH] =
            flg.crc_match_flag;
        nxt_packet_and_output_status[`RSRB_PKT_CARRIER] =
            carrier_sense_i;
        nxt_packet_and_output_status[`RSRB_PKT_PREAMBLE] =
            preamble_quality_met_i;
        nxt_packet_and_output_status[`RSRB_PKT_CHANNEL_CLEAR] =
            channel_clear_flag_i;
        nxt_packet_and_output_status[`RSRB_PKT_SYNC] =
            sync_found_flag_i;
        // a lock indication on an output is only a sampled level here,
        // too coarse to judge lock from
        nxt_packet_and_output_status[`RSRB_PKT_OUT_TWO] =
            gp_two_plain;
        nxt_packet_and_output_status[`RSRB_PKT_OUT_ONE] =
            gp_output_one_i;
        nxt_packet_and_output_status[`RSRB_PKT_OUT_ZERO] =
            gp_zero_plain;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wake_timer_low_byte_ff <= `RSRB_BYTE_RESET;
        end else begin
            wake_timer_low_byte_ff <= wake_timer_count_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            packet_and_output_status_ff <= `RSRB_BYTE_RESET;
        end else begin
            packet_and_output_status_ff <= nxt_packet_and_output_status;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            oscillator_calibration_readback_ff <= `RSRB_BYTE_RESET;
        end else begin
            oscillator_calibration_readback_ff <= osc_tuning_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            transmit_buffer_level_ff <= `RSRB_BYTE_RESET;
        end else begin
            transmit_buffer_level_ff <= pack_level(
                flg.tx_underflow_flag, transmit_byte_count_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            receive_buffer_level_ff <= `RSRB_BYTE_RESET;
        end else begin
            receive_buffer_level_ff <= pack_level(
                flg.rx_overflow_flag, receive_byte_count_i);
        end
    end

    assign rd_sel = decode_header(rd_header_i);

    always_comb begin
        nxt_rd_data = `RSRB_BYTE_RESET;
        unique case (rd_sel)
            rsrb_pkg::RSRB_SEL_WOR_LOW: begin
                nxt_rd_data = wake_timer_low_byte_ff;
            end
            rsrb_pkg::RSRB_SEL_PKT: begin
                nxt_rd_data = packet_and_output_status_ff;
            end
            rsrb_pkg::RSRB_SEL_CAL: begin
                nxt_rd_data = oscillator_calibration_readback_ff;
            end
            rsrb_pkg::RSRB_SEL_TX: begin
                nxt_rd_data = transmit_buffer_level_ff;
            end
            rsrb_pkg::RSRB_SEL_RX: begin
                nxt_rd_data = receive_buffer_level_ff;
            end
            rsrb_pkg::RSRB_SEL_NONE: begin
                nxt_rd_data = `RSRB_BYTE_RESET;
            end
            default: begin
                nxt_rd_data = `RSRB_BYTE_RESET;
            end
        endcase
    end

    // read data holds until the next request; valid and miss are pulses
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_data_ff <= `RSRB_BYTE_RESET;
        end else if (rd_req_i) begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_valid_ff <= `RSRB_BIT_RESET;
            rd_miss_ff <= `RSRB_BIT_RESET;
        end else begin
            rd_valid_ff <= rd_req_i;
            rd_miss_ff <= rd_req_i && (rd_sel == rsrb_pkg::RSRB_SEL_NONE);
        end
    end

    assign rd_data_o = rd_data_ff;
    assign rd_valid_o = rd_valid_ff;
    assign rd_miss_o = rd_miss_ff;
endmodule

// [bench/rsrb_host_model.sv]
module rsrb_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i,
    input wire logic rd_miss_i,
    output logic rd_req_o,
    output logic [7:0] rd_header_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rd_req_o = 1'b0;
        rd_header_o = 8'h00;
    end
    // entered at a falling edge; the answer is sampled one cycle later
    // lock is judged elsewhere, never from an output status bit
    task automatic read(input logic [7:0] hdr, output logic [7:0] data,
                        output logic miss, output logic ok);
        rd_req_o = 1'b1;
        rd_header_o = hdr;
        @(negedge clk_i);
        rd_req_o = 1'b0;
        // a released header must not keep its last value
        rd_header_o = ~hdr;
        ok = rd_valid_i;
        data = rd_data_i;
        miss = rd_miss_i;
    endtask
endmodule

// [bench/rsrb_status_checker.sv]
module rsrb_status_checker (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic rd_req_i,
    input wire logic [7:0] rd_header_i,
    input wire logic [7:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic rd_miss_o,
    input wire logic [15:0] wake_timer_count_i,
    input wire logic carrier_sense_i,
    input wire logic preamble_quality_met_i,
    input wire logic channel_clear_flag_i,
    input wire logic sync_found_flag_i,
    input wire logic gp_output_two_i,
    input wire logic gp_output_one_i,
    input wire logic gp_output_zero_i,
    input wire logic output_two_invert_i,
    input wire logic output_zero_invert_i,
    input wire logic [7:0] osc_tuning_i,
    input wire logic [6:0] transmit_byte_count_i,
    input wire logic [6:0] receive_byte_count_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // images hold data one edge old, so the answer shows inputs two back
    sequence s_rd(logic [7:0] a);
        rd_req_i && rd_header_i == a && !$past(reset_i);
    endsequence
    property p_answer;
        rd_req_i |=> rd_valid_o;
    endproperty
    property p_miss;
        rd_req_i && rd_header_i[7:6] != 2'b11
            |=> rd_valid_o && rd_miss_o && rd_data_o == 8'h00;
    endproperty
    property p_wake;
        s_rd(8'hF7) |=> rd_data_o == $past(wake_timer_count_i[7:0], 2);
    endproperty
    property p_outs;
        s_rd(8'hF8) |=> rd_data_o[2:0] == $past({gp_output_two_i ^
            output_two_invert_i, gp_output_one_i,
            gp_output_zero_i ^ output_zero_invert_i}, 2);
    endproperty
    property p_live;
        s_rd(8'hF8) |=> rd_data_o[6:3] == $past({carrier_sense_i,
            preamble_quality_met_i, channel_clear_flag_i,
            sync_found_flag_i}, 2);
    endproperty
    property p_cal;
        s_rd(8'hF9) |=> rd_data_o == $past(osc_tuning_i, 2);
    endproperty
    property p_tx;
        s_rd(8'hFA) |=> rd_data_o[6:0] == $past(transmit_byte_count_i, 2);
    endproperty
    property p_rx;
        s_rd(8'hFB) |=> rd_data_o[6:0] == $past(receive_byte_count_i, 2);
    endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    a_miss: assert property (p_miss) else $error("bad header not refused");
    a_wake: assert property (p_wake) else $error("timer byte wrong");
    a_outs: assert property (p_outs) else $error("output bits wrong");
    a_live: assert property (p_live) else $error("live bits wrong");
    a_cal: assert property (p_cal) else $error("tuning byte wrong");
    a_tx: assert property (p_tx) else $error("tx count wrong");
    a_rx: assert property (p_rx) else $error("rx count wrong");
    c_pkt: cover property (s_rd(8'hF8));
    c_miss: cover property (rd_valid_o && rd_miss_o);
    c_crc: cover property (s_rd(8'hF8) ##1 rd_data_o[7]);
endmodule

bind rsrb_status_bank rsrb_status_checker chk_u (.*);

// [bench/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, reset_i, rd_req_i, rd_valid_o, rd_miss_o;
    logic [7:0] rd_header_i, rd_data_o, osc_tuning_i, got, hdr;
    logic [15:0] wake_timer_count_i;
    logic crc_done_i, crc_match_i, rx_enter_i, carrier_sense_i;
    logic preamble_quality_met_i, channel_clear_flag_i, sync_found_flag_i;
    logic gp_output_two_i, gp_output_one_i, gp_output_zero_i;
    logic output_two_invert_i, output_zero_invert_i;
    logic [6:0] transmit_byte_count_i, receive_byte_count_i;
    logic tx_underflow_evt_i, tx_flush_i, rx_overflow_evt_i, rx_flush_i;
    logic crc_f, tx_f, rx_f, miss, ok;
    logic [31:0] seed = 32'h076E, r;
    int err_total = 0, n_compared = 0, cyc = 0;

    rsrb_status_bank dut_u (.*);
    rsrb_host_model host_u (
        .clk_i(clk_i),
        .rd_data_i(rd_data_o),
        .rd_valid_i(rd_valid_o),
        .rd_miss_i(rd_miss_o),
        .rd_req_o(rd_req_i),
        .rd_header_o(rd_header_i)
    );

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] expect_of(logic [7:0] h);
        case (h)
            8'hF7: return wake_timer_count_i[7:0];
            8'hF8: return {crc_f, carrier_sense_i, preamble_quality_met_i,
                channel_clear_flag_i, sync_found_flag_i,
                gp_output_two_i ^ output_two_invert_i, gp_output_one_i,
                gp_output_zero_i ^ output_zero_invert_i};
            8'hF9: return osc_tuning_i;
            8'hFA: return {tx_f, transmit_byte_count_i};
            8'hFB: return {rx_f, receive_byte_count_i};
            default: return 8'h00;
        endcase
    endfunction

    task automatic cmp(input logic [9:0] g, input logic [9:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic check(input logic [7:0] h);
        logic em;
        logic [7:0] ed;
        em = h[7:6] != 2'b11 || h[5:0] < 6'h37 || h[5:0] > 6'h3B;
        ed = expect_of(h);
        host_u.read(h, got, miss, ok);
        cmp({ok, miss, got}, {1'b1, em, ed});
        @(negedge clk_i);
        // valid and miss are one-cycle pulses, the data byte stays
        cmp({rd_valid_o, rd_miss_o, rd_data_o}, {2'b00, em ? 8'h00 : ed});
    endtask

    task automatic read_all();
        for (int k = 0; k < 5; k++) begin
            hdr = 8'hF7 + 8'(k);
            check(hdr);
        end
    endtask

    task automatic set_levels(input logic [31:0] a, input logic [31:0] b);
        wake_timer_count_i = a[15:0];
        osc_tuning_i = a[23:16];
        {carrier_sense_i, preamble_quality_met_i, channel_clear_flag_i,
            sync_found_flag_i, gp_output_two_i, gp_output_one_i,
            gp_output_zero_i, output_two_invert_i} = b[7:0];
        output_zero_invert_i = b[8];
        transmit_byte_count_i = b[15:9];
        receive_byte_count_i = b[22:16];
    endtask

    task automatic pulse(input logic [6:0] v);
        {crc_done_i, crc_match_i, rx_enter_i, tx_underflow_evt_i,
            tx_flush_i, rx_overflow_evt_i, rx_flush_i} = v;
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // about 520 cycles are needed; far more means a hang
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        reset_i = 1'b1;
        set_levels(32'h0, 32'h0);
        pulse(7'h00);
        {crc_f, tx_f, rx_f} = 3'b000;
        repeat (16) @(negedge clk_i);
        reset_i = 1'b0;
        cmp({rd_valid_o, rd_miss_o, rd_data_o}, 10'h000);
        @(negedge clk_i);
        for (int i = 0; i < 40; i++) begin
            set_levels(xs(), xs());
            if (i == 0)
                {transmit_byte_count_i, receive_byte_count_i} = 14'h3FFF;
            r = xs();
            pulse(r[6:0]);
            crc_f = crc_done_i ? crc_match_i : crc_f & ~rx_enter_i;
            tx_f = tx_underflow_evt_i | (tx_f & ~tx_flush_i);
            rx_f = rx_overflow_evt_i | (rx_f & ~rx_flush_i);
            @(negedge clk_i);
            pulse(7'h00);
            @(negedge clk_i);
            read_all();
        end
        for (int k = 0; k < 5; k++) begin
            check(8'h37 + 8'(k) * 8'h41);
        end
        // offsets just outside the status space with a full header
        check(8'hFC);
        check(8'hF6);
        reset_i = 1'b1;
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
        {crc_f, tx_f, rx_f} = 3'b000;
        @(negedge clk_i);
        read_all();
        summarize();
    end
endmodule
